// *** logic/axle_torque_signal.sv ***
// Axle torque signal publisher with AXI4-Lite registers
`timescale 1ns/1ns
module axle_torque_signal #(
	parameter int PUBLISH_CYCLES = axle_torque_pkg::PUBLISH_PERIOD_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Driver requests from torque shaping
	input wire axle_torque_pkg::driver_requests_t requests,
	input wire logic requests_ok,
	input wire logic reverse_range,
	input wire axle_torque_pkg::torque_nm_t max_torque,
	input wire logic max_torque_ok,
	// Adaptive cruise command and answer
	input wire logic acc_cmd_valid,
	input wire axle_torque_pkg::torque_nm_t acc_cmd_torque,
	output logic acc_answer_valid,
	output axle_torque_pkg::acc_answer_t acc_answer,
	// Received brake apply flag
	input wire logic brake_apply_pin,
	// Published frame
	output axle_torque_pkg::published_frame_t frame,
	output logic frame_strobe,
	// Interrupt
	output logic irq
);
	localparam int TIMER_W = $clog2(PUBLISH_CYCLES + 1);
	localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(PUBLISH_CYCLES - 1);

	logic [31:0] ctrl;
	logic [axle_torque_pkg::RATIO_RAW_W-1:0] ratio_cal;
	axle_torque_pkg::torque_nm_t brake_comp;
	logic [axle_torque_pkg::EVENT_W-1:0] status;
	logic [axle_torque_pkg::EVENT_W-1:0] mask;
	logic [axle_torque_pkg::EVENT_W-1:0] events;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic read_take;
	logic status_read;
	logic brake_meta;
	logic brake_sync;
	logic brake_prev;
	logic [TIMER_W-1:0] timer;
	logic tick;
	axle_torque_pkg::torque_sum_t target;
	axle_torque_pkg::torque_sum_t filtered;
	axle_torque_pkg::torque_sum_t next_filtered;
	axle_torque_pkg::torque_sum_t max_wide;
	logic [axle_torque_pkg::TORQUE_RAW_W-1:0] torque_raw;
	logic torque_bad;
	logic [axle_torque_pkg::TORQUE_RAW_W-1:0] max_raw;
	logic max_bad;
	logic [axle_torque_pkg::CTRL_SHIFT_W-1:0] filter_shift;
	logic publish_on;
	logic acc_over;
	logic [31:0] merged;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] result;
		result = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				result[8*i +: 8] = data[8*i +: 8];
			end
		end
		return result;
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		return addr == axle_torque_pkg::ADDR_CTRL || addr == axle_torque_pkg::ADDR_RATIO
			|| addr == axle_torque_pkg::ADDR_BRAKE_COMP || addr == axle_torque_pkg::ADDR_STATUS
			|| addr == axle_torque_pkg::ADDR_MASK || addr == axle_torque_pkg::ADDR_LIVE;
	endfunction

	assign filter_shift = ctrl[axle_torque_pkg::CTRL_SHIFT_LSB +: axle_torque_pkg::CTRL_SHIFT_W];
	assign publish_on = ctrl[axle_torque_pkg::CTRL_ENABLE_BIT];

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= axle_torque_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_addr) ? axle_torque_pkg::RESP_OKAY
				: axle_torque_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Old register word with the written byte lanes laid over it
	always_comb begin
		case (aw_addr)
			axle_torque_pkg::ADDR_CTRL: begin
				merged = merge(ctrl, w_data, w_strb);
			end
			axle_torque_pkg::ADDR_RATIO: begin
				merged = merge(32'(ratio_cal), w_data, w_strb);
			end
			axle_torque_pkg::ADDR_BRAKE_COMP: begin
				merged = merge(32'(unsigned'(brake_comp)), w_data, w_strb);
			end
			axle_torque_pkg::ADDR_MASK: begin
				merged = merge(32'(mask), w_data, w_strb);
			end
			default: begin
				merged = w_data;
			end
		endcase
	end

	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= axle_torque_pkg::CTRL_RESET;
			ratio_cal <= axle_torque_pkg::RATIO_RESET;
			brake_comp <= '0;
			mask <= '0;
		end else if (do_write) begin
			case (aw_addr)
				axle_torque_pkg::ADDR_CTRL: begin
					ctrl <= merged;
				end
				axle_torque_pkg::ADDR_RATIO: begin
					ratio_cal <= merged[axle_torque_pkg::RATIO_RAW_W-1:0];
				end
				axle_torque_pkg::ADDR_BRAKE_COMP: begin
					brake_comp <= merged[axle_torque_pkg::TORQUE_NM_W-1:0];
				end
				axle_torque_pkg::ADDR_MASK: begin
					mask <= merged[axle_torque_pkg::EVENT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read channel: one cycle to data, one read in flight
	assign s_axi_arready = !s_axi_rvalid;
	assign read_take = s_axi_arvalid && s_axi_arready;
	assign status_read = read_take && s_axi_araddr == axle_torque_pkg::ADDR_STATUS;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= axle_torque_pkg::RESP_OKAY;
		end else if (read_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? axle_torque_pkg::RESP_OKAY
				: axle_torque_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				axle_torque_pkg::ADDR_CTRL: s_axi_rdata <= ctrl;
				axle_torque_pkg::ADDR_RATIO: s_axi_rdata <= 32'(ratio_cal);
				axle_torque_pkg::ADDR_BRAKE_COMP: s_axi_rdata <= 32'(unsigned'(brake_comp));
				axle_torque_pkg::ADDR_STATUS: s_axi_rdata <= 32'(status);
				axle_torque_pkg::ADDR_MASK: s_axi_rdata <= 32'(mask);
				axle_torque_pkg::ADDR_LIVE: begin
					s_axi_rdata <= {brake_sync, max_bad, torque_bad, 14'h0000, torque_raw};
				end
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Brake flag arrives from the network receiver, so it is synchronised
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brake_meta <= 1'b0;
			brake_sync <= 1'b0;
			brake_prev <= 1'b0;
		end else begin
			brake_meta <= brake_apply_pin;
			brake_sync <= brake_meta;
			brake_prev <= brake_sync;
		end
	end

	// Driver torque: all five request sources, acc and braking included, enter the sum
	always_comb begin
		target = axle_torque_pkg::torque_sum_t'(requests.pedal)
			+ axle_torque_pkg::torque_sum_t'(requests.cruise)
			+ axle_torque_pkg::torque_sum_t'(requests.acc)
			+ axle_torque_pkg::torque_sum_t'(requests.pto)
			+ axle_torque_pkg::torque_sum_t'(requests.braking);
		// Braking by the brake module looks like extra resistance
		if (brake_sync) begin
			target = target + axle_torque_pkg::torque_sum_t'(brake_comp);
		end
		// Inputs are in shaft sense; flip so positive means intended travel
		if (reverse_range) begin
			target = -target;
		end
		next_filtered = filtered + ((target - filtered) >>> filter_shift);
	end

	// Shift 0 passes the target straight through; larger shifts slow response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filtered <= '0;
		end else if (!requests_ok) begin
			filtered <= target;
		end else begin
			filtered <= next_filtered;
		end
	end

	assign max_wide = axle_torque_pkg::torque_sum_t'(max_torque);

	torque_field_encoder torque_enc (
		.value_nm(filtered),
		.value_ok(requests_ok),
		.raw(torque_raw),
		.invalid(torque_bad)
	);

	torque_field_encoder max_enc (
		.value_nm(max_wide),
		.value_ok(max_torque_ok),
		.raw(max_raw),
		.invalid(max_bad)
	);

	// Adaptive cruise requests limited to the published maximum
	assign acc_over = acc_cmd_torque > max_torque;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_answer_valid <= 1'b0;
			acc_answer <= '0;
		end else begin
			acc_answer_valid <= acc_cmd_valid;
			if (acc_cmd_valid) begin
				acc_answer.torque <= acc_over ? max_torque : acc_cmd_torque;
				acc_answer.honored <= 1'b1;
				acc_answer.limited_max <= acc_over;
			end
		end
	end

	// Period timer for publishing; period stays far under the ratio input delay
	assign tick = publish_on && timer == TIMER_LAST;

	always_ff @(posedge aclk) begin
		if (!aresetn || !publish_on || tick) begin
			timer <= '0;
		end else begin
			timer <= timer + TIMER_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame <= '0;
			frame.torque_invalid <= axle_torque_pkg::FLAG_INVALID;
			frame.torque_max_invalid <= axle_torque_pkg::FLAG_INVALID;
			frame_strobe <= 1'b0;
		end else begin
			frame_strobe <= tick;
			if (tick) begin
				frame.axle_ratio <= ratio_cal;
				frame.torque <= torque_raw;
				frame.torque_invalid <= torque_bad;
				frame.torque_max <= max_raw;
				frame.torque_max_invalid <= max_bad;
			end
		end
	end

	// Sticky events; a new event beats the read that clears it
	always_comb begin
		events = '0;
		events[axle_torque_pkg::EV_ACC_LIMITED] = acc_cmd_valid && acc_over;
		events[axle_torque_pkg::EV_TORQUE_INVALID] = tick && torque_bad;
		events[axle_torque_pkg::EV_BRAKE_APPLY] = brake_sync && !brake_prev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
		end else begin
			status <= (status & ~(status_read ? status : '0)) | events;
		end
	end

	assign irq = |(status & mask);
endmodule

// *** logic/axle_torque_pkg.sv ***
// Shared constants, field layouts and carriers of the axle torque signal block
package axle_torque_pkg;
	// Torque scaling: engineering = raw * 2 - offset
	localparam int TORQUE_RAW_W = 15;
	localparam int TORQUE_NM_W = 17;
	localparam int TORQUE_SUM_W = 20;
	localparam int TORQUE_OFFSET_NM = 22534;
	localparam int TORQUE_TOP_NM = 43000;
	localparam int TORQUE_NM_PER_COUNT_LOG2 = 1;
	// Axle ratio: engineering = raw * 0.01 + 2.00
	localparam int RATIO_RAW_W = 9;
	localparam logic [8:0] RATIO_RESET = 9'h000;
	// Validity encoding
	localparam logic FLAG_VALID = 1'b0;
	localparam logic FLAG_INVALID = 1'b1;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int PUBLISH_PERIOD_US = 10000;
	localparam int PUBLISH_PERIOD_CYCLES = PUBLISH_PERIOD_US * CLK_MHZ;
	localparam int RATIO_INPUT_DELAY_MS = 1000;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RATIO = 8'h04;
	localparam logic [7:0] ADDR_BRAKE_COMP = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_MASK = 8'h10;
	localparam logic [7:0] ADDR_LIVE = 8'h14;
	// Control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_SHIFT_LSB = 4;
	localparam int CTRL_SHIFT_W = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0021;
	// Status and mask bits
	localparam int EVENT_W = 3;
	localparam int EV_ACC_LIMITED = 0;
	localparam int EV_TORQUE_INVALID = 1;
	localparam int EV_BRAKE_APPLY = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic signed [TORQUE_NM_W-1:0] torque_nm_t;
	typedef logic signed [TORQUE_SUM_W-1:0] torque_sum_t;

	typedef struct packed {
		torque_nm_t pedal;
		torque_nm_t cruise;
		torque_nm_t acc;
		torque_nm_t pto;
		torque_nm_t braking;
	} driver_requests_t;

	typedef struct packed {
		logic [RATIO_RAW_W-1:0] axle_ratio;
		logic [TORQUE_RAW_W-1:0] torque;
		logic torque_invalid;
		logic [TORQUE_RAW_W-1:0] torque_max;
		logic torque_max_invalid;
	} published_frame_t;

	typedef struct packed {
		torque_nm_t torque;
		logic honored;
		logic limited_max;
	} acc_answer_t;
endpackage

// *** logic/torque_field_encoder.sv ***
// Engineering torque to 15-bit network raw field with range check
`timescale 1ns/1ns
module torque_field_encoder (
	// Engineering value in N*m
	input wire axle_torque_pkg::torque_sum_t value_nm,
	input wire logic value_ok,
	// Raw field and validity
	output logic [axle_torque_pkg::TORQUE_RAW_W-1:0] raw,
	output logic invalid
);
	axle_torque_pkg::torque_sum_t shifted;
	logic below;
	logic above;

	always_comb begin
		shifted = value_nm + axle_torque_pkg::torque_sum_t'(axle_torque_pkg::TORQUE_OFFSET_NM);
		below = value_nm < -axle_torque_pkg::torque_sum_t'(axle_torque_pkg::TORQUE_OFFSET_NM);
		above = value_nm > axle_torque_pkg::torque_sum_t'(axle_torque_pkg::TORQUE_TOP_NM);
		// Saturate so an out-of-range value never wraps to a wild raw
		if (below) begin
			raw = '0;
		end else if (above) begin
			raw = '1;
		end else begin
			raw = shifted[axle_torque_pkg::TORQUE_NM_PER_COUNT_LOG2 +: axle_torque_pkg::TORQUE_RAW_W];
		end
		invalid = (!value_ok || below || above) ? axle_torque_pkg::FLAG_INVALID
			: axle_torque_pkg::FLAG_VALID;
	end
endmodule

// *** tb/axle_torque_props.sv ***
// Port-level checks of the axle torque signal block
`timescale 1ns/1ns
module axle_torque_props #(
	parameter int PUBLISH_CYCLES = 20
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Torque and cruise
	input wire axle_torque_pkg::torque_nm_t max_torque,
	input wire logic max_torque_ok,
	input wire logic acc_cmd_valid,
	input wire axle_torque_pkg::torque_nm_t acc_cmd_torque,
	input wire logic acc_answer_valid,
	input wire axle_torque_pkg::acc_answer_t acc_answer,
	// Frame
	input wire axle_torque_pkg::published_frame_t frame,
	input wire logic frame_strobe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_ACC_CLAMP: assert property (acc_cmd_valid && acc_cmd_torque > max_torque
		|=> acc_answer_valid && acc_answer.torque == $past(max_torque)
		&& acc_answer.honored && acc_answer.limited_max) else $error("acc clamp wrong");
	AST_ACC_PASS: assert property (acc_cmd_valid && acc_cmd_torque <= max_torque
		|=> acc_answer_valid && acc_answer.torque == $past(acc_cmd_torque)
		&& acc_answer.honored && !acc_answer.limited_max) else $error("acc pass wrong");
	AST_ACC_ONCE: assert property (acc_answer_valid |-> $past(acc_cmd_valid))
		else $error("acc answer without command");
	AST_STROBE: assert property (frame_strobe |=> !frame_strobe)
		else $error("strobe longer than a cycle");
	AST_FRAME_HOLD: assert property (!frame_strobe |-> $stable(frame))
		else $error("frame changed off tick");
	AST_MAX_INV: assert property (frame_strobe && !$past(max_torque_ok)
		|-> frame.torque_max_invalid) else $error("max not flagged invalid");
	AST_MAX_RAW: assert property (frame_strobe && $past(max_torque_ok)
		&& $past(max_torque) >= -22534 && $past(max_torque) <= 43000
		|-> !frame.torque_max_invalid
		&& frame.torque_max == 15'(($past(max_torque) + 22534) >>> 1))
		else $error("max field wrong");
	AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_B_HOLD: assert property (s_axi_bvalid |=> s_axi_bvalid == !$past(s_axi_bready))
		else $error("write response not held or not released");
	cover property (acc_cmd_valid && acc_cmd_torque > max_torque);
	cover property (frame_strobe && frame.torque_invalid);
	cover property (s_axi_bvalid && s_axi_awready == 1'b0);
endmodule
bind axle_torque_signal axle_torque_props #(.PUBLISH_CYCLES(PUBLISH_CYCLES)) props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .max_torque(max_torque),
	.max_torque_ok(max_torque_ok), .acc_cmd_valid(acc_cmd_valid),
	.acc_cmd_torque(acc_cmd_torque), .acc_answer_valid(acc_answer_valid),
	.acc_answer(acc_answer), .frame(frame), .frame_strobe(frame_strobe));

// *** tb/brake_node_model.sv ***
// Brake controller and frame receiver at the network side
`timescale 1ns/1ns
module brake_node_model #(
	parameter bit FITTED = 1'b1
) (
	// Clock
	input wire logic aclk,
	// Bench command and published frame
	input wire logic apply,
	input wire axle_torque_pkg::published_frame_t frame,
	input wire logic frame_strobe,
	// Brake flag and last usable torque
	output logic brake_flag,
	output logic [14:0] held_torque
);
	// Unfitted sender never reports an apply
	always_ff @(posedge aclk) brake_flag <= FITTED & apply;
	// Invalid torque ignored, last valid value kept
	always_ff @(posedge aclk) begin
		if (frame_strobe && !frame.torque_invalid)
			held_torque <= frame.torque;
	end
endmodule

// *** tb/tb_axle_torque_signal.sv ***
// Self-checking bench of the axle torque signal block
`timescale 1ns/1ns
module tb_axle_torque_signal;
	localparam int PC = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, strobe, ans_v, brake;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [14:0] held, h;
	logic req_ok = 1'b1, rev = 1'b0, max_ok = 1'b1, cmd_v = 1'b0, apply = 1'b0;
	axle_torque_pkg::driver_requests_t req = '0;
	axle_torque_pkg::torque_nm_t maxt = 17'h0a7f8;
	axle_torque_pkg::torque_nm_t cmdt = 17'h00000;
	axle_torque_pkg::acc_answer_t ans;
	axle_torque_pkg::published_frame_t frame;
	int n_errors = 0;
	int compares = 0;
	always #5 aclk = ~aclk;
	axle_torque_signal #(.PUBLISH_CYCLES(PC)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.requests(req), .requests_ok(req_ok), .reverse_range(rev), .max_torque(maxt),
		.max_torque_ok(max_ok), .acc_cmd_valid(cmd_v), .acc_cmd_torque(cmdt),
		.acc_answer_valid(ans_v), .acc_answer(ans), .brake_apply_pin(brake),
		.frame(frame), .frame_strobe(strobe), .irq(irq));
	brake_node_model #(.FITTED(1'b1)) far (.aclk(aclk), .apply(apply), .frame(frame),
		.frame_strobe(strobe), .brake_flag(brake), .held_torque(held));
	task conclude;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bail;
		chk(32'h0, 32'h1);
		conclude();
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (k == 50) bail();
		chk(32'(bresp), 32'(er));
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (k == 50) bail();
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
	endtask
	task automatic wait_frame(input int n);
		int k;
		for (k = 0; k < 20 * PC && n > 0; k++) begin
			@(posedge aclk);
			if (strobe) n--;
		end
		if (n > 0) bail();
	endtask
	task do_reset;
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task t_reset;
		@(posedge aclk);
		chk(32'(frame.torque_invalid), 32'h1);
		chk(32'(frame.torque_max_invalid), 32'h1);
		chk(32'(irq), 32'h0);
		axr(axle_torque_pkg::ADDR_CTRL, axle_torque_pkg::CTRL_RESET, 2'h0);
		axr(axle_torque_pkg::ADDR_MASK, 32'h0, 2'h0);
		// Only lane 1 enabled, so the mask bits in lane 0 must stay clear
		wstrb <= 4'h2;
		axw(axle_torque_pkg::ADDR_MASK, 32'h0000_0007, 2'h0);
		wstrb <= 4'hf;
		axr(axle_torque_pkg::ADDR_MASK, 32'h0, 2'h0);
		axw(8'h18, 32'h0000_0001, axle_torque_pkg::RESP_SLVERR);
		axr(8'h18, 32'h0, axle_torque_pkg::RESP_SLVERR);
	endtask
	task t_encode;
		axw(axle_torque_pkg::ADDR_RATIO, 32'h1f5, 2'h0);
		// Filter shift 0 so the published value settles in one cycle
		axw(axle_torque_pkg::ADDR_CTRL, 32'h1, 2'h0);
		req.pedal <= 17'h003e8;
		req.cruise <= 17'h000c8;
		req.acc <= 17'h0012c;
		req.pto <= 17'h00032;
		req.braking <= 17'h1fe0c;
		wait_frame(2);
		chk(32'(frame.torque), 32'h2e10);
		chk(32'(frame.torque_invalid), 32'h0);
		chk(32'(frame.torque_max), 32'h7fff);
		chk(32'(frame.axle_ratio), 32'h1f5);
		rev <= 1'b1;
		maxt <= 17'h1a7fa;
		wait_frame(2);
		chk(32'(frame.torque), 32'h29f6);
		chk(32'(frame.torque_max), 32'h0);
		chk(32'(frame.torque_max_invalid), 32'h0);
		rev <= 1'b0;
	endtask
	task t_invalid;
		axw(axle_torque_pkg::ADDR_MASK, 32'h2, 2'h0);
		wait_frame(1);
		h = frame.torque;
		req_ok <= 1'b0;
		max_ok <= 1'b0;
		// New torque while invalid, so the receiver must keep the old one
		req.pedal <= 17'h007d0;
		wait_frame(1);
		chk(32'(frame.torque_invalid), 32'h1);
		chk(32'(frame.torque_max_invalid), 32'h1);
		chk(32'(held), 32'(h));
		chk(32'(irq), 32'h1);
		req_ok <= 1'b1;
		max_ok <= 1'b1;
		req.pedal <= 17'h003e8;
		axr(axle_torque_pkg::ADDR_STATUS, 32'h2, 2'h0);
		@(posedge aclk);
		chk(32'(irq), 32'h0);
	endtask
	task t_acc;
		@(posedge aclk);
		maxt <= 17'h003e8;
		cmdt <= 17'h005dc;
		cmd_v <= 1'b1;
		@(posedge aclk);
		cmdt <= 17'h00320;
		@(posedge aclk);
		cmd_v <= 1'b0;
		chk(32'(ans_v), 32'h1);
		chk(32'(ans), 32'h0000_0fa3);
		chk(32'({ans.honored, ans.limited_max}), 32'h3);
		@(posedge aclk);
		chk(32'(ans.torque), 32'h00320);
		chk(32'({ans.honored, ans.limited_max}), 32'h2);
		axr(axle_torque_pkg::ADDR_STATUS, 32'h1, 2'h0);
	endtask
	task t_brake;
		maxt <= 17'h0a7f8;
		axw(axle_torque_pkg::ADDR_BRAKE_COMP, 32'h64, 2'h0);
		apply <= 1'b1;
		wait_frame(2);
		chk(32'(frame.torque), 32'h2e42);
		axr(axle_torque_pkg::ADDR_LIVE, 32'h80002e42, 2'h0);
		axr(axle_torque_pkg::ADDR_STATUS, 32'h4, 2'h0);
		apply <= 1'b0;
	endtask
	initial begin
		do_reset();
		t_reset();
		t_encode();
		t_invalid();
		t_acc();
		t_brake();
		do_reset();
		t_reset();
		conclude();
	end
endmodule
